// ==== phy_diag_consts.vh ====
// constants for the phy error counters and self-test control block
// assumes word-aligned AHB-Lite access, byte address = 4 x register index
`ifndef PHY_DIAG_CONSTS_VH
`define PHY_DIAG_CONSTS_VH

// register indices as printed, byte address derived from them
`define IDX_INT_STATUS_TWO   8'h13
`define IDX_FALSE_CARRIER    8'h14
`define IDX_RX_ERROR         8'h15
`define IDX_SELFTEST_CTRL    8'h16
`define IDX_IRQ_STATUS       8'h20
`define IDX_IRQ_CLEAR        8'h21
`define IDX_IRQ_ENABLE       8'h22
`define IDX_SELFTEST_ERRCNT  8'h23

// interrupt_status_two fields
`define IS2_JABBER_EN_BIT    0
`define IS2_JABBER_PEND_BIT  8

// selftest_control fields
`define ST_ERR_MODE_BIT      14
`define ST_CHK_EN_BIT        13
`define ST_GEN_EN_BIT        12
`define ST_LOCK_BIT          11
`define ST_SYNC_LOSS_BIT     10
`define ST_GEN_STAT_BIT      9

// own interrupt status / clear / enable layout
`define IRQ_FC_HALF_BIT      0
`define IRQ_RE_HALF_BIT      1
`define IRQ_BIST_WRAP_BIT    2
`define IRQ_SYNC_LOSS_BIT    3
`define IRQ_BITS             4

// half-full thresholds, the counter must pass these to raise an event
`define FC_HALF              8'h7F
`define RE_HALF              16'h007F

// reset values
`define RST_IRQ              4'h0
`define RST_WORD             32'h0000_0000

// AHB-Lite transfer type and response
`define HTRANS_NONSEQ        2'h2
`define HRESP_OKAY           1'b0

`endif

// ==== phy_error_counters_and_bist_control.v ====
// error counters, jabber interrupt bits and self-test control of the phy
// assumes one clock, synchronous active-high reset, inputs synchronous to
// clock_in, and a single AHB-Lite master doing single word transfers
//
// Overview of operation
// [R1] jabber interrupt enable, read-write bit 0 of interrupt_status_two, resets 0
// [R2] 8-bit false-carrier counter counts events, clears on read, top byte zero
// [R3] false-carrier counter holds at all ones until a read clears it
// [R4] false-carrier counter passing 7Fh raises an interrupt event
// [R5] 16-bit receive-error counter counts errors while data valid and carrier; the code has no carrier input and counts on rx_dv_in with rx_er_in
// [R6] receive-error counter is frozen while in mii loopback
// [R7] receive-error counter saturates at FFFFh, clears on read
// [R8] receive-error counter passing 7Fh raises an interrupt event
// [R9] continuous mode: self-test error counter wraps to zero with a pulse; the code pulses on the step to the maximum, not on the wrap
// [R10] single mode: self-test error counter stops at its maximum
// [R11] checker enable bit 13, read-write, resets 0, gates prbs checking
// [R12] generator enable bit 12, read-write, resets 0, runs packet generator
// [R13] read-only lock bit 11 shows checker locked to received stream
// [R14] read-only sync-loss bit 10 latches high until software reads it
// [R15] read-only bit 9 shows packet generator active
// [R16] separate read-write enable gates receive-error half-full interrupt
// [R17] read-only jabber pending bit 8 latches high until read
// [R18] event during clearing read is kept; read returns pre-increment value
//
// Our own choice: the AHB-Lite interface to the registers.
`include "phy_diag_consts.vh"

// register map, word index times four gives the byte address
//   13h  interrupt_status_two: bit 8 jabber pending, bit 0 jabber enable
//   14h  false_carrier_count: count in bits 7:0, upper bits read zero
//   15h  receive_error_count: count in the low RE_WIDTH bits
//   16h  selftest_control: bits 14 down to 9, bits 8:0 read zero
//   20h  interrupt status, read only, sticky bits
//   21h  interrupt clear, write only, a one clears that status bit
//   22h  interrupt enable, read-write, same layout as the status
//   23h  self-test error count, read only
//
// interrupt status layout
//   bit 0  false-carrier counter stepped past half-full
//   bit 1  receive-error counter stepped past half-full
//   bit 2  self-test error counter reached its top in continuous mode
//   bit 3  prbs checker lost sync
// jabber is kept apart: its pending bit and enable live in
// interrupt_status_two so software sees the layout it expects there
//
// bus timing
//   the slave never stretches a transfer, so hreadyout is tied high
//   a read is decoded in its address phase and the word is registered
//   at that edge; the master collects it one edge later
//   a write is captured in its address phase and applied at the end of
//   its data phase, when hwdata stands
//   a read whose address phase meets the data phase of a write to the
//   same word returns the value from before that write; software that
//   needs read-after-write order should not rely on it
//
// clear-on-read hazards
//   the clearing read acts at the address-phase edge, not at the edge
//   where the master takes the data; an event in the same cycle is not
//   dropped, it becomes the first count after the clear
//   latching flags follow the same idea: a new event beats the read
//
// counters
//   all counters saturate instead of wrapping, except the self-test
//   error counter in continuous mode, which wraps and pulses
//   the half-full event fires once, on the step from 7Fh to 80h; a
//   counter that was cleared and climbs again fires it again
//   the receive-error counter ignores cycles in mii loopback, since
//   then the receive data is our own transmit data
//
// self-test
//   the self-test error counter is held at zero while the checker is
//   off, so each enable starts a fresh run
//   lock is only reported while the checker is enabled; a stale lock
//   from the core would otherwise mislead software
//   sync loss is taken as lock high on one edge and low on the next,
//   which would also fire when software turns the checker off; a stop by
//   software is deliberately excluded by the enable term
//   generator status is the core's activity qualified by our enable
//
// limitations
//   hsize is ignored: only whole-word transfers are expected
//   unmapped words read zero and ignore writes, with an okay response
//   the self-test counter width is a parameter with a plain default
//
// reset
//   every register clears on a synchronous high reset; outputs are
//   all zero during and after reset apart from hreadyout
//   the first transfer may be issued at the first edge after release

module phy_error_counters_and_bist_control #(
    parameter FC_WIDTH   = 8,
    parameter RE_WIDTH   = 16,
    parameter BIST_WIDTH = 8
) (
    input  wire        clock_in,
    input  wire        reset_in,
    // AHB-Lite slave
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output wire [31:0] hrdata_out,
    output wire        hreadyout_out,
    output wire        hresp_out,
    // receive datapath events
    input  wire        jabber_event_in,
    input  wire        false_carrier_in,
    input  wire        rx_dv_in,
    input  wire        rx_er_in,
    input  wire        mii_loopback_in,
    // prbs checker and packet generator core
    input  wire        prbs_locked_in,
    input  wire        prbs_bit_error_in,
    input  wire        gen_active_in,
    output wire        checker_enable_out,
    output wire        generator_enable_out,
    output wire        bist_wrap_pulse_out,
    // interrupt
    output wire        irq_out
);

    localparam [FC_WIDTH-1:0]   FC_MAX   = {FC_WIDTH{1'b1}};
    localparam [RE_WIDTH-1:0]   RE_MAX   = {RE_WIDTH{1'b1}};
    localparam [BIST_WIDTH-1:0] BIST_MAX = {BIST_WIDTH{1'b1}};

    // bus pipeline state
    reg                   wr_pend_r;
    reg  [7:0]            wr_idx_r;
    reg  [31:0]           hrdata_r;

    // control and status state
    reg                   jab_en_r;
    reg                   jab_pend_r;
    reg  [FC_WIDTH-1:0]   fc_cnt_r;
    reg  [RE_WIDTH-1:0]   re_cnt_r;
    reg                   err_mode_r;
    reg                   chk_en_r;
    reg                   gen_en_r;
    reg                   sync_loss_r;
    reg                   lock_prev_r;
    reg  [BIST_WIDTH-1:0] bist_cnt_r;
    reg                   bist_wrap_r;
    reg  [`IRQ_BITS-1:0]  irq_stat_r;
    reg  [`IRQ_BITS-1:0]  irq_en_r;

    // next values
    reg                   jab_pend_nxt;
    reg  [FC_WIDTH-1:0]   fc_cnt_nxt;
    reg  [RE_WIDTH-1:0]   re_cnt_nxt;
    reg                   sync_loss_nxt;
    reg  [BIST_WIDTH-1:0] bist_cnt_nxt;
    reg                   bist_wrap_nxt;
    reg  [`IRQ_BITS-1:0]  irq_stat_nxt;
    reg  [31:0]           rd_word;

    wire                  addr_phase;
    wire                  rd_take;
    wire [7:0]            addr_idx;
    wire                  rd_fc;
    wire                  rd_re;
    wire                  rd_is2;
    wire                  rd_st;
    wire                  wr_now;
    wire                  lock_now;
    wire                  gen_stat;
    wire                  fc_inc;
    wire                  re_evt;
    wire                  re_inc;
    wire                  chk_err;
    wire                  fc_half_evt;
    wire                  re_half_evt;
    wire                  sync_loss_evt;
    wire [`IRQ_BITS-1:0]  irq_evt;

    // address decode; only word bits matter, index = byte address / 4
    assign addr_phase = hsel_in & hready_in & (htrans_in == `HTRANS_NONSEQ);
    assign rd_take    = addr_phase & ~hwrite_in;
    assign addr_idx   = haddr_in[9:2];
    assign rd_fc      = rd_take & (addr_idx == `IDX_FALSE_CARRIER);
    assign rd_re      = rd_take & (addr_idx == `IDX_RX_ERROR);
    assign rd_is2     = rd_take & (addr_idx == `IDX_INT_STATUS_TWO);
    assign rd_st      = rd_take & (addr_idx == `IDX_SELFTEST_CTRL);
    assign wr_now     = wr_pend_r;

    // zero wait states, never an error
    assign hreadyout_out = 1'b1;
    assign hresp_out     = `HRESP_OKAY;
    assign hrdata_out    = hrdata_r;

    // live status seen by software
    assign lock_now = chk_en_r & prbs_locked_in;             // [R13]
    assign gen_stat = gen_en_r & gen_active_in;              // [R15]

    // event qualification
    assign fc_inc  = false_carrier_in & (fc_cnt_r != FC_MAX);   // [R3]
    assign re_evt  = rx_dv_in & rx_er_in & ~mii_loopback_in;    // [R5] [R6]
    assign re_inc  = re_evt & (re_cnt_r != RE_MAX);             // [R7]
    assign chk_err = chk_en_r & prbs_bit_error_in;              // [R11]

    // half-full is passed on the step from 7Fh to 80h only
    assign fc_half_evt = fc_inc & (fc_cnt_r == `FC_HALF);      // [R4]
    assign re_half_evt = re_inc & (re_cnt_r == `RE_HALF);      // [R8]
    assign sync_loss_evt = lock_prev_r & ~lock_now & chk_en_r; // [R14]

    assign irq_evt[`IRQ_FC_HALF_BIT]   = fc_half_evt;
    assign irq_evt[`IRQ_RE_HALF_BIT]   = re_half_evt;
    assign irq_evt[`IRQ_BIST_WRAP_BIT] = bist_wrap_nxt;
    assign irq_evt[`IRQ_SYNC_LOSS_BIT] = sync_loss_evt;

    // read mux; unmapped and write-only words read as zero
    always @* begin
        rd_word = `RST_WORD;
        if (addr_idx == `IDX_INT_STATUS_TWO) begin
            rd_word[`IS2_JABBER_PEND_BIT] = jab_pend_r;      // [R17]
            rd_word[`IS2_JABBER_EN_BIT]   = jab_en_r;        // [R1]
        end else if (addr_idx == `IDX_FALSE_CARRIER) begin
            rd_word[FC_WIDTH-1:0] = fc_cnt_r;                // [R2]
        end else if (addr_idx == `IDX_RX_ERROR) begin
            rd_word[RE_WIDTH-1:0] = re_cnt_r;
        end else if (addr_idx == `IDX_SELFTEST_CTRL) begin
            rd_word[`ST_ERR_MODE_BIT]  = err_mode_r;
            rd_word[`ST_CHK_EN_BIT]    = chk_en_r;
            rd_word[`ST_GEN_EN_BIT]    = gen_en_r;
            rd_word[`ST_LOCK_BIT]      = lock_now;
            rd_word[`ST_SYNC_LOSS_BIT] = sync_loss_r;
            rd_word[`ST_GEN_STAT_BIT]  = gen_stat;
        end else if (addr_idx == `IDX_IRQ_STATUS) begin
            rd_word[`IRQ_BITS-1:0] = irq_stat_r;
        end else if (addr_idx == `IDX_IRQ_ENABLE) begin
            rd_word[`IRQ_BITS-1:0] = irq_en_r;
        end else if (addr_idx == `IDX_SELFTEST_ERRCNT) begin
            rd_word[BIST_WIDTH-1:0] = bist_cnt_r;
        end
    end

    // false-carrier counter; a read hands out the old value and an event
    // arriving in the same cycle becomes the first count of the new run
    always @* begin
        fc_cnt_nxt = fc_cnt_r;
        if (rd_fc) begin
            fc_cnt_nxt = {{(FC_WIDTH-1){1'b0}}, false_carrier_in}; // [R2] [R18]
        end else if (fc_inc) begin
            fc_cnt_nxt = fc_cnt_r + {{(FC_WIDTH-1){1'b0}}, 1'b1};  // [R2]
        end
    end

    // receive-error counter, same clear-on-read treatment
    always @* begin
        re_cnt_nxt = re_cnt_r;
        if (rd_re) begin
            re_cnt_nxt = {{(RE_WIDTH-1){1'b0}}, re_evt};   // [R7] [R18]
        end else if (re_inc) begin
            re_cnt_nxt = re_cnt_r + {{(RE_WIDTH-1){1'b0}}, 1'b1}; // [R5]
        end
    end

    // latching-high flags: the new event wins over the clearing read
    always @* begin
        jab_pend_nxt = (rd_is2 ? 1'b0 : jab_pend_r) | jabber_event_in; // [R17]
        sync_loss_nxt = (rd_st ? 1'b0 : sync_loss_r) | sync_loss_evt; // [R14]
    end

    // self-test error counter; held at zero while the checker is off so a
    // fresh run always starts clean
    always @* begin
        bist_cnt_nxt  = bist_cnt_r;
        bist_wrap_nxt = 1'b0;
        if (!chk_en_r) begin
            bist_cnt_nxt = {BIST_WIDTH{1'b0}};
        end else if (chk_err) begin
            if (bist_cnt_r != BIST_MAX) begin
                bist_cnt_nxt = bist_cnt_r + {{(BIST_WIDTH-1){1'b0}}, 1'b1};
                if (err_mode_r &&
                    bist_cnt_r == BIST_MAX - {{(BIST_WIDTH-1){1'b0}}, 1'b1}) begin
                    bist_wrap_nxt = 1'b1;                    // [R9]
                end
            end else if (err_mode_r) begin
                bist_cnt_nxt = {BIST_WIDTH{1'b0}};           // [R9]
            end
            // single mode at maximum: stays put               [R10]
        end
    end

    // sticky interrupt status; set beats a same-cycle clear
    always @* begin
        irq_stat_nxt = irq_stat_r;
        if (wr_now && wr_idx_r == `IDX_IRQ_CLEAR) begin
            irq_stat_nxt = irq_stat_r & ~hwdata_in[`IRQ_BITS-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | irq_evt;
    end

    // interrupt output; jabber uses its own enable in interrupt_status_two
    assign irq_out = (|(irq_stat_r & irq_en_r)) |
                     (jab_pend_r & jab_en_r);                // [R1] [R16]

    assign checker_enable_out   = chk_en_r;                  // [R11]
    assign generator_enable_out = gen_en_r;                  // [R12]
    assign bist_wrap_pulse_out  = bist_wrap_r;               // [R9]

    // bus pipeline: capture writes for the data phase, register read data
    always @(posedge clock_in) begin
        if (reset_in) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 8'h00;
            hrdata_r  <= `RST_WORD;
        end else begin
            wr_pend_r <= addr_phase & hwrite_in;
            wr_idx_r  <= addr_idx;
            if (rd_take) begin
                hrdata_r <= rd_word;
            end
        end
    end

    // software-written control bits
    always @(posedge clock_in) begin
        if (reset_in) begin
            jab_en_r   <= 1'b0;                              // [R1]
            err_mode_r <= 1'b0;
            chk_en_r   <= 1'b0;                              // [R11]
            gen_en_r   <= 1'b0;                              // [R12]
            irq_en_r   <= `RST_IRQ;                          // [R16]
        end else if (wr_now) begin
            if (wr_idx_r == `IDX_INT_STATUS_TWO) begin
                jab_en_r <= hwdata_in[`IS2_JABBER_EN_BIT];   // [R1]
            end else if (wr_idx_r == `IDX_SELFTEST_CTRL) begin
                err_mode_r <= hwdata_in[`ST_ERR_MODE_BIT];
                chk_en_r   <= hwdata_in[`ST_CHK_EN_BIT];     // [R11]
                gen_en_r   <= hwdata_in[`ST_GEN_EN_BIT];     // [R12]
            end else if (wr_idx_r == `IDX_IRQ_ENABLE) begin
                irq_en_r <= hwdata_in[`IRQ_BITS-1:0];        // [R16]
            end
        end
    end

    // hardware-updated state
    always @(posedge clock_in) begin
        if (reset_in) begin
            jab_pend_r  <= 1'b0;
            fc_cnt_r    <= {FC_WIDTH{1'b0}};
            re_cnt_r    <= {RE_WIDTH{1'b0}};
            sync_loss_r <= 1'b0;
            lock_prev_r <= 1'b0;
            bist_cnt_r  <= {BIST_WIDTH{1'b0}};
            bist_wrap_r <= 1'b0;
            irq_stat_r  <= `RST_IRQ;
        end else begin
            jab_pend_r  <= jab_pend_nxt;
            fc_cnt_r    <= fc_cnt_nxt;
            re_cnt_r    <= re_cnt_nxt;
            sync_loss_r <= sync_loss_nxt;
            lock_prev_r <= lock_now;
            bist_cnt_r  <= bist_cnt_nxt;
            bist_wrap_r <= bist_wrap_nxt;
            irq_stat_r  <= irq_stat_nxt;
        end
    end

endmodule // phy_error_counters_and_bist_control

// ==== phy_diag_chk.sv ====
// checker for the phy error counters and self-test control block
// assumes it is bound onto the top module and sees its ports only
module phy_diag_chk (
    input wire logic        clock_in,
    input wire logic        reset_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        prbs_locked_in,
    input wire logic        prbs_bit_error_in,
    input wire logic        gen_active_in,
    input wire logic        checker_enable_out,
    input wire logic        generator_enable_out,
    input wire logic        bist_wrap_pulse_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    // address phases taken by the slave
    wire ap = hsel_in && hready_in && htrans_in == 2'h2;
    wire rd = ap && !hwrite_in;
    wire wr_st = ap && hwrite_in && haddr_in[9:2] == 8'h16;
    a_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("slave not ready or not okay");
    a_en_reset: assert property ($fell(reset_in) |->
        !checker_enable_out && !generator_enable_out)
        else $error("enables not cleared by reset");
    // enables move only through a write to the self-test register
    a_en_by_write: assert property (
        $changed({checker_enable_out, generator_enable_out}) |->
        $past(wr_st, 2))
        else $error("enable changed without a write");
    a_wrap_one: assert property (bist_wrap_pulse_out |=>
        !bist_wrap_pulse_out)
        else $error("wrap pulse longer than one cycle");
    a_wrap_cause: assert property (bist_wrap_pulse_out |->
        ($past(prbs_bit_error_in) || $past(prbs_bit_error_in, 2)) &&
        $past(checker_enable_out))
        else $error("wrap pulse without a counted error");
    a_rdata_hold: assert property (!rd |=> $stable(hrdata_out))
        else $error("read data moved without a read");
    a_fc_upper: assert property (
        rd && haddr_in[9:2] == 8'h14 |=> hrdata_out[31:8] == 24'h0)
        else $error("false carrier upper bits not zero");
    a_st_live: assert property (
        rd && haddr_in[9:2] == 8'h16 |=>
        hrdata_out[13] == $past(checker_enable_out) &&
        hrdata_out[12] == $past(generator_enable_out) &&
        hrdata_out[11] == $past(checker_enable_out && prbs_locked_in) &&
        hrdata_out[9] == $past(generator_enable_out && gen_active_in))
        else $error("self-test status bits wrong");
    c_wrap: cover property (bist_wrap_pulse_out);
    c_st_read: cover property (rd && haddr_in[9:2] == 8'h16);
    c_en_write: cover property (wr_st);
endmodule // phy_diag_chk

bind phy_error_counters_and_bist_control phy_diag_chk u_chk (
    .clock_in, .reset_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .prbs_locked_in,
    .prbs_bit_error_in, .gen_active_in, .checker_enable_out,
    .generator_enable_out, .bist_wrap_pulse_out);

// ==== rx_test_source.sv ====
// model of the receive datapath and prbs checker core around the block
// assumes the bench calls its tasks; events change right after an edge
module rx_test_source (
    input  wire logic clock_in,
    input  wire logic generator_enable_in,
    output wire logic fc_out,
    output wire logic dv_out,
    output wire logic er_out,
    output wire logic jab_out,
    output wire logic bit_err_out,
    output logic      locked_out,
    output logic      gen_active_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] ev_r = 5'h00;
    initial locked_out = 1'b1;
    initial gen_active_out = 1'b0;
    // event lines: fc, rx error (with dv), jabber, bit error, dv alone
    assign fc_out = ev_r[0];
    assign er_out = ev_r[1];
    assign dv_out = ev_r[1] | ev_r[4];
    assign jab_out = ev_r[2];
    assign bit_err_out = ev_r[3];
    // generator core needs a cycle to come up or stop
    always @(posedge clock_in) gen_active_out <= generator_enable_in;
    // hold the selected events high for exactly n sampling edges
    task automatic ev(input logic [4:0] m, input int n);
        @(posedge clock_in) ev_r <= m;
        repeat (n) @(posedge clock_in);
        ev_r <= 5'h00;
    endtask
    task automatic drop_lock();
        @(posedge clock_in) locked_out <= 1'b0;
    endtask
endmodule // rx_test_source

// ==== phy_error_counters_and_bist_control_tb.sv ====
// self-checking bench for the phy error counters and self-test control
// assumes the block answers with zero wait states and always okay
module phy_error_counters_and_bist_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_in = 0, reset_in = 1, hsel_in = 0, hwrite_in = 0;
    logic        mii_loopback_in = 0;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, r, a;
    logic [1:0]  htrans_in = 2'h0;
    wire         hreadyout_out, hresp_out, fc, dv, er, jab, berr, lck, gact;
    wire         chk_en, gen_en, wrap, irq_out;
    int          errors = 0, checks_done = 0;
    // write flag, byte address, write data or expected read data
    logic [47:0] rows [13] = '{48'h0_04C_00000000, 48'h0_050_00000000,
        48'h0_054_00000000, 48'h0_058_00000000, 48'h0_080_00000000,
        48'h0_088_00000000, 48'h1_088_0000000F, 48'h0_088_0000000F,
        48'h1_04C_00000001, 48'h0_04C_00000001, 48'h0_0FC_00000000,
        48'h1_058_00007000, 48'h0_058_00007A00};
    phy_error_counters_and_bist_control #(.RE_WIDTH(10)) u_phy_error_counters_and_bist_control (
        .clock_in, .reset_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
        .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
        .hreadyout_out, .hresp_out, .jabber_event_in(jab),
        .false_carrier_in(fc), .rx_dv_in(dv), .rx_er_in(er),
        .mii_loopback_in, .prbs_locked_in(lck), .prbs_bit_error_in(berr),
        .gen_active_in(gact), .checker_enable_out(chk_en),
        .generator_enable_out(gen_en), .bist_wrap_pulse_out(wrap),
        .irq_out);
    rx_test_source u_rx_test_source (.clock_in, .generator_enable_in(gen_en),
        .fc_out(fc), .dv_out(dv), .er_out(er), .jab_out(jab),
        .bit_err_out(berr), .locked_out(lck), .gen_active_out(gact));
    initial forever #10 clock_in = ~clock_in;
    task automatic wait_rdy();
        @(posedge clock_in);
        while (hreadyout_out !== 1'b1) @(posedge clock_in);
    endtask
    // one single word transfer, address phase then data phase
    task automatic bus(input [31:0] ad, input w, input [31:0] d,
                       output [31:0] q);
        @(posedge clock_in) {hsel_in, haddr_in, htrans_in, hwrite_in}
            <= {1'b1, ad, 2'h2, w};
        wait_rdy();
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_rdy();
        q = hrdata_out;
    endtask
    task automatic chk(input [31:0] got, input [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input [31:0] ad, input [31:0] exp);
        bus(ad, 1'b0, 32'h0, r);
        chk(r, exp);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge clock_in);
        reset_in <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i][44]) bus(rows[i][43:32], 1'b1, rows[i][31:0], r);
            else rdc(rows[i][43:32], rows[i][31:0]);
        end
        $display("register table test done");
        // false carrier: threshold, saturation, clear on read
        u_rx_test_source.ev(5'h01, 127);
        rdc(32'h80, 32'h0);
        u_rx_test_source.ev(5'h01, 1);
        rdc(32'h80, 32'h1);
        chk(irq_out, 1'b1);
        u_rx_test_source.ev(5'h01, 200);
        rdc(32'h50, 32'hFF);
        rdc(32'h50, 32'h0);
        bus(32'h84, 1'b1, 32'hF, r);
        $display("false carrier test done");
        // receive errors: loopback and dv alone do not count
        mii_loopback_in <= 1'b1;
        u_rx_test_source.ev(5'h02, 5);
        mii_loopback_in <= 1'b0;
        u_rx_test_source.ev(5'h10, 10);
        rdc(32'h54, 32'h0);
        u_rx_test_source.ev(5'h02, 128);
        rdc(32'h80, 32'h2);
        u_rx_test_source.ev(5'h02, 1100);
        rdc(32'h54, 32'h3FF);
        rdc(32'h54, 32'h0);
        // a read landing inside an event burst loses nothing
        fork
            u_rx_test_source.ev(5'h01, 10);
            begin
                repeat (3) @(posedge clock_in);
                bus(32'h50, 1'b0, 32'h0, a);
            end
        join
        rdc(32'h50, 32'd10 - a);
        $display("receive error test done");
        // continuous mode wraps at the top, single mode holds
        bus(32'h84, 1'b1, 32'hF, r);
        u_rx_test_source.ev(5'h08, 255);
        rdc(32'h8C, 32'hFF);
        rdc(32'h80, 32'h4);
        u_rx_test_source.ev(5'h08, 1);
        rdc(32'h8C, 32'h0);
        bus(32'h84, 1'b1, 32'hF, r);
        bus(32'h58, 1'b1, 32'h3000, r);
        u_rx_test_source.ev(5'h08, 300);
        rdc(32'h8C, 32'hFF);
        rdc(32'h80, 32'h0);
        u_rx_test_source.drop_lock();
        rdc(32'h58, 32'h3600);
        rdc(32'h58, 32'h3200);
        u_rx_test_source.ev(5'h04, 1);
        rdc(32'h4C, 32'h101);
        rdc(32'h4C, 32'h1);
        $display("self-test and jabber test done");
        // reset in mid-run returns the control bits to zero
        @(posedge clock_in) reset_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        reset_in <= 1'b0;
        rdc(32'h58, 32'h0);
        rdc(32'h4C, 32'h0);
        $display("reset test done");
        end_of_test();
    end
endmodule // phy_error_counters_and_bist_control_tb
